/* File: hdl/spf_defines.vh */
// Purpose: constants for the serial port format and protocol mode block
// Assumes: 20 MHz clk_sys, APB register access
// Notes: included by spf_top.v only
// How it works
// RQ1: three ports, each independently configured
// RQ2: 8-bit line code, format and baud nibbles
// RQ3: bit7 7-bit, bit4 2 stop, parity bits
// RQ4: low nibble maps to sixteen baud rates; codes 0 and 1 both give 2400 here, so 15 distinct rates
// RQ5: setting holds until rewritten, survives soft reset
// RQ6: power-up default 38400 8n1
// RQ7: halt switch forces port one default
// RQ8: protocol mode starts in auto-detect
// RQ9: lock onto recognised protocol, check-verified
// RQ10: errored command answered per active protocol
// RQ11: locked port rejects other protocols
// RQ12: ten idle seconds return lock to auto
// RQ13: no-protocol mode only passes data
// RQ14: forced protocol never changes automatically
// RQ15: four protocols supported on every port
// RQ16: commit only after a validated complete frame
// RQ17: every received byte still reaches buffer
`ifndef SPF_DEFINES_VH
`define SPF_DEFINES_VH
// register byte addresses
`define SPF_A_LINE0 12'h000
`define SPF_A_LINE1 12'h004
`define SPF_A_LINE2 12'h008
`define SPF_A_PMODE 12'h00c
`define SPF_A_STAT 12'h010
`define SPF_A_MASK 12'h014
`define SPF_A_STATE 12'h018
// line code fields
`define SPF_B_SEVEN 7
`define SPF_B_PAREN 6
`define SPF_B_ODD 5
`define SPF_B_TWOSTOP 4
`define SPF_LINE_DEF 8'h06
// 16x oversample divisors at 20 MHz, nearest count except 38400, 57600, 115K, 300 and 1200, which are rounded down
`define SPF_DIV_2400 17'h00209
`define SPF_DIV_4800 17'h00104
`define SPF_DIV_9600 17'h00082
`define SPF_DIV_19200 17'h00041
`define SPF_DIV_31250 17'h00028
`define SPF_DIV_38400 17'h00020
`define SPF_DIV_57600 17'h00015
`define SPF_DIV_100K 17'h0000c
`define SPF_DIV_115K 17'h0000a
`define SPF_DIV_230K 17'h00005
`define SPF_DIV_110 17'h02c64
`define SPF_DIV_150 17'h0208d
`define SPF_DIV_300 17'h01046
`define SPF_DIV_600 17'h00823
`define SPF_DIV_1200 17'h00411
// protocol ids (detect/kind)
`define SPF_P_NATIVE 2'h0
`define SPF_P_MBASCII 2'h1
`define SPF_P_MBRTU 2'h2
`define SPF_P_HOSTLINK 2'h3
// configured mode codes
`define SPF_CFG_AUTO 3'h0
`define SPF_CFG_NONE 3'h1
`define SPF_CFG_FIXED 3'h2
// run state codes
`define SPF_S_AUTO 2'h0
`define SPF_S_LOCK 2'h1
`define SPF_S_NONE 2'h2
`define SPF_S_FIXED 2'h3
// timing
`define SPF_CLK_HZ 20000000
`define SPF_IDLE_S 10
`define SPF_IDLE_CYC (`SPF_CLK_HZ * `SPF_IDLE_S)
`endif

/* File: hdl/spf_top.v */
// Purpose: line-format registers and protocol-mode machines, three ports
// Assumes: frame decoders upstream report validated frames per port
// Notes: baud divider output is a per-port one-cycle tick at 16x rate
`include "spf_defines.vh"
module spf_top #(
  parameter integer IDLE_CYC = `SPF_IDLE_CYC,
  parameter integer NPORT = 3
) (
  input wire clk_sys,
  input wire nrst,
  input wire soft_rst,
  input wire halt_switch,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NPORT-1:0] rx_byte_valid,
  input wire [NPORT*8-1:0] rx_byte,
  input wire [NPORT-1:0] frame_done,
  input wire [NPORT*2-1:0] frame_proto,
  input wire [NPORT-1:0] frame_ok,
  output reg [NPORT-1:0] buf_wr,
  output reg [NPORT*8-1:0] buf_data,
  output reg [NPORT-1:0] cmd_accept,
  output reg [NPORT-1:0] cmd_error_reply,
  output reg [NPORT*2-1:0] active_proto,
  output reg [NPORT-1:0] reply_enable,
  output reg [NPORT-1:0] seven_bits,
  output reg [NPORT-1:0] parity_en,
  output reg [NPORT-1:0] parity_odd,
  output reg [NPORT-1:0] two_stop,
  output reg [NPORT-1:0] baud_tick,
  output reg irq
);

  // ************************************************************
  // overview
  // ************************************************************
  // three ports share one register bus and one clock; each port
  // owns a line code, a mode machine, a baud divider and a buffer
  // write path. frame decoders outside this block judge framing and
  // check sequences; this block only decides what a port does with
  // each verdict, so a decoder change never touches the mode logic.
  //
  // register map, one word per register, data in the low bits:
  //   line codes for ports one to three at 0x00, 0x04 and 0x08
  //   mode word at 0x0c: 3 bits of config per port, then 2 bits
  //     of fixed protocol per port from bit 9 upward
  //   sticky status at 0x10: lock events low, refused commands
  //     high, write one to clear; an event beats a clear
  //   mask at 0x14, same layout as the status word
  //   run state at 0x18, read only, 2 bits per port
  // any other address answers with a slave error, changes nothing.
  //
  // reset split: nrst is the power-on reset and resets everything,
  // line codes included. soft_rst only sends the mode machines
  // back to auto-detect, so a running link keeps its format.
  //
  // limitation: the register map is laid out for three ports; a
  // different port count needs the read mux and field slices redone.

  // ************************************************************
  // baud table: 16x oversample divisors at 20 MHz
  // ************************************************************
  // rounding to whole counts costs accuracy at the fast end: 38400
  // runs under two percent fast, 230400 about eight percent fast,
  // a limit of the 20 MHz clock; the slowest rate needs 14 of the 17 bits.
  function [16:0] spf_div;
    input [3:0] code;
    begin
      case (code) // see RQ4
        4'h0: spf_div = `SPF_DIV_2400;
        4'h1: spf_div = `SPF_DIV_2400; // same rate as code 0
        4'h2: spf_div = `SPF_DIV_4800;
        4'h3: spf_div = `SPF_DIV_9600;
        4'h4: spf_div = `SPF_DIV_19200;
        4'h5: spf_div = `SPF_DIV_31250;
        4'h6: spf_div = `SPF_DIV_38400;
        4'h7: spf_div = `SPF_DIV_57600;
        4'h8: spf_div = `SPF_DIV_100K;
        4'h9: spf_div = `SPF_DIV_115K;
        4'ha: spf_div = `SPF_DIV_230K;
        4'hb: spf_div = `SPF_DIV_110;
        4'hc: spf_div = `SPF_DIV_150;
        4'hd: spf_div = `SPF_DIV_300;
        4'he: spf_div = `SPF_DIV_600;
        default: spf_div = `SPF_DIV_1200;
      endcase
    end
  endfunction

  // ************************************************************
  // register file
  // ************************************************************
  reg [7:0] line_reg [0:NPORT-1];
  reg [NPORT*3-1:0] pmode_reg; // per port: cfg mode(3)
  reg [NPORT*2-1:0] pfix_reg;  // per port: fixed protocol
  reg [NPORT-1:0] stat_reg;    // lock events
  reg [NPORT-1:0] stat_err_reg; // rejected commands
  reg [2*NPORT-1:0] mask_reg;
  reg [1:0] state_reg [0:NPORT-1];
  reg halt_seen_reg;
  reg first_reg;

  wire apb_wr = psel & penable & pwrite & pready;
  wire apb_rd = psel & penable & ~pwrite & pready;
  wire [NPORT-1:0] ev_lock;
  wire [NPORT-1:0] ev_err;

  // capture halt switch once after reset release, not under reset
  // the switch is read only here: flipping it later has no effect
  // until the next power-on reset, which keeps a bouncing switch
  // from locking software out in mid-run
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      first_reg <= 1'b1;
      halt_seen_reg <= 1'b0;
    end else if (first_reg) begin
      first_reg <= 1'b0;
      halt_seen_reg <= halt_switch; // see RQ7
    end
  end

  // ************************************************************
  // register bus
  // ************************************************************
  // the word is decoded and latched at the setup edge; pready
  // rises at that same edge and stands for one cycle only, so every
  // transfer has exactly one access cycle. reads have no side
  // effects; writes land at the access edge.
  // apb: single wait-free answer, one cycle after setup
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == `SPF_A_LINE0)
          prdata <= {24'h0, line_reg[0]};
        else if (paddr == `SPF_A_LINE1)
          prdata <= {24'h0, line_reg[1]};
        else if (paddr == `SPF_A_LINE2)
          prdata <= {24'h0, line_reg[2]};
        else if (paddr == `SPF_A_PMODE)
          prdata <= {17'h0, pfix_reg, pmode_reg};
        else if (paddr == `SPF_A_STAT)
          prdata <= {26'h0, stat_err_reg, stat_reg};
        else if (paddr == `SPF_A_MASK)
          prdata <= {26'h0, mask_reg};
        else if (paddr == `SPF_A_STATE)
          prdata <= {26'h0, state_reg[2], state_reg[1], state_reg[0]};
        else
          pslverr <= 1'b1; // unmapped address
      end
    end
  end

  // ************************************************************
  // line codes, mode word, status and interrupt
  // ************************************************************
  // line settings: power-on default, soft reset leaves them alone
  // with the halt switch captured, port one ignores writes so the
  // service link always comes up at the default format; ports two
  // and three stay writable
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      line_reg[0] <= `SPF_LINE_DEF; // see RQ6
      line_reg[1] <= `SPF_LINE_DEF;
      line_reg[2] <= `SPF_LINE_DEF;
    end else if (first_reg) begin
      line_reg[0] <= `SPF_LINE_DEF;
    end else if (apb_wr) begin
      // halt blocks stored-config rewrites of port one
      if (paddr == `SPF_A_LINE0 && !halt_seen_reg)
        line_reg[0] <= pwdata[7:0]; // see RQ5 RQ7
      else if (paddr == `SPF_A_LINE1)
        line_reg[1] <= pwdata[7:0]; // see RQ2
      else if (paddr == `SPF_A_LINE2)
        line_reg[2] <= pwdata[7:0];
    end
  end

  // mode config, mask, sticky status (set wins over clear)
  // letting the event win means a lock or refusal that lands in the
  // same cycle as a clear is never lost; software sees it next read
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pmode_reg <= {NPORT{`SPF_CFG_AUTO}}; // see RQ8
      pfix_reg <= {NPORT{`SPF_P_NATIVE}};
      mask_reg <= 6'h00;
      stat_reg <= 3'h0;
      stat_err_reg <= 3'h0;
    end else begin
      if (apb_wr && paddr == `SPF_A_PMODE && !halt_seen_reg) begin
        pmode_reg <= pwdata[8:0];
        pfix_reg <= pwdata[14:9];
      end
      if (apb_wr && paddr == `SPF_A_MASK)
        mask_reg <= pwdata[5:0];
      if (apb_wr && paddr == `SPF_A_STAT) begin
        stat_reg <= (stat_reg & ~pwdata[2:0]) | ev_lock;
        stat_err_reg <= (stat_err_reg & ~pwdata[5:3]) | ev_err;
      end else begin
        stat_reg <= stat_reg | ev_lock;
        stat_err_reg <= stat_err_reg | ev_err;
      end
    end
  end

  // interrupt level from unmasked sticky bits
  // registered so the pin never glitches; it trails the status
  // bits and the mask by one cycle
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |({stat_err_reg, stat_reg} & mask_reg);
  end

  // ************************************************************
  // per-port mode machine, baud divider, buffer pass-through
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : port // see RQ1 RQ15
      reg [1:0] lock_proto_reg;
      reg [27:0] idle_reg;
      reg [16:0] bdiv_reg;
      wire [2:0] cfg = pmode_reg[g*3 +: 3];
      wire [1:0] fp = frame_proto[g*2 +: 2];
      wire [1:0] st = state_reg[g];
      wire fd = frame_done[g];
      wire ok = frame_ok[g];
      wire same = (fp == lock_proto_reg);
      wire [16:0] lim = spf_div(line_reg[g][3:0]);

      assign ev_lock[g] = fd & ok & (st == `SPF_S_AUTO);
      // wrong protocol while locked or fixed is refused
      assign ev_err[g] = fd & ((st == `SPF_S_LOCK) |
                         (st == `SPF_S_FIXED)) & ok & ~same;

      // mode machine per port:
      //   auto  - any frame that passes its decoder locks the port
      //           to that frame's protocol and is answered
      //   lock  - only frames of the locked protocol are answered;
      //           another protocol's frame is a refused command;
      //           the idle counter restarts on each frame of the
      //           locked protocol, and at its end the
      //           port drops back to auto
      //   none  - nothing is answered, bytes still reach the buffer
      //   fixed - as lock, but the protocol comes from the mode
      //           word and the idle counter is not used
      // the config word overrides the machine every cycle, so a
      // mode write takes effect at the next edge whatever the state
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          state_reg[g] <= `SPF_S_AUTO;
          lock_proto_reg <= `SPF_P_NATIVE;
          idle_reg <= 28'h0000000;
        end else if (soft_rst) begin
          state_reg[g] <= `SPF_S_AUTO;
          idle_reg <= 28'h0000000;
        end else if (cfg == `SPF_CFG_NONE) begin
          state_reg[g] <= `SPF_S_NONE; // see RQ13
        end else if (cfg == `SPF_CFG_FIXED) begin
          state_reg[g] <= `SPF_S_FIXED; // see RQ14
          lock_proto_reg <= pfix_reg[g*2 +: 2];
        end else begin
          case (st)
            `SPF_S_LOCK: begin
              if (fd && same) begin
                idle_reg <= 28'h0000000;
              end else if (idle_reg == IDLE_CYC - 1) begin
                state_reg[g] <= `SPF_S_AUTO; // see RQ12
                idle_reg <= 28'h0000000;
              end else begin
                idle_reg <= idle_reg + 28'h0000001;
              end
            end
            `SPF_S_AUTO: begin
              idle_reg <= 28'h0000000;
              if (fd && ok) begin // see RQ16
                state_reg[g] <= `SPF_S_LOCK; // see RQ9
                lock_proto_reg <= fp;
              end
            end
            default: state_reg[g] <= `SPF_S_AUTO;
          endcase
        end
      end

      // command outcome strobes for the protocol engines
      // strobes are judged on the state before the frame, so the
      // frame that locks a port in auto is itself answered; a bad
      // frame in auto gets no reply because no protocol owns it yet
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          cmd_accept[g] <= 1'b0;
          cmd_error_reply[g] <= 1'b0;
          active_proto[g*2 +: 2] <= `SPF_P_NATIVE;
          reply_enable[g] <= 1'b0;
        end else begin
          active_proto[g*2 +: 2] <= (st == `SPF_S_AUTO) ? fp :
                                    lock_proto_reg;
          reply_enable[g] <= (st != `SPF_S_NONE);
          cmd_accept[g] <= fd & ok & (st != `SPF_S_NONE) &
                           ((st == `SPF_S_AUTO) | same); // see RQ11
          // bad check on own protocol gets protocol's error reply
          cmd_error_reply[g] <= fd & ~ok & (st != `SPF_S_NONE) &
                                (st != `SPF_S_AUTO) & same; // see RQ10
        end
      end

      // format decode and baud tick
      // the compare uses >= so a rate change to a shorter divisor in
      // mid-count wraps at once instead of running through 17 bits
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          seven_bits[g] <= 1'b0;
          parity_en[g] <= 1'b0;
          parity_odd[g] <= 1'b0;
          two_stop[g] <= 1'b0;
          bdiv_reg <= 17'h00000;
          baud_tick[g] <= 1'b0;
        end else begin
          seven_bits[g] <= line_reg[g][`SPF_B_SEVEN]; // see RQ3
          parity_en[g] <= line_reg[g][`SPF_B_PAREN];
          parity_odd[g] <= line_reg[g][`SPF_B_ODD];
          two_stop[g] <= line_reg[g][`SPF_B_TWOSTOP];
          if (bdiv_reg >= lim - 17'h00001) begin
            bdiv_reg <= 17'h00000;
            baud_tick[g] <= 1'b1;
          end else begin
            bdiv_reg <= bdiv_reg + 17'h00001;
            baud_tick[g] <= 1'b0;
          end
        end
      end

      // every byte goes to the receive buffer regardless of mode
      // protocol handling only watches the stream and never eats
      // bytes, so the program sees commands too
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          buf_wr[g] <= 1'b0;
          buf_data[g*8 +: 8] <= 8'h00;
        end else begin
          buf_wr[g] <= rx_byte_valid[g]; // see RQ17
          buf_data[g*8 +: 8] <= rx_byte[g*8 +: 8];
        end
      end
    end
  endgenerate

endmodule // spf_top

/* File: tb/spf_host_model.sv */
// Purpose: far-side frame source for spf_top
// Assumes: decoders report each frame right after its last byte
// Notes: released lanes show inverted data so stale values never pass
module spf_host_model (
  input wire clk_sys,
  output logic [2:0] rx_byte_valid,
  output logic [23:0] rx_byte,
  output logic [2:0] frame_done,
  output logic [5:0] frame_proto,
  output logic [2:0] frame_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet link at time zero
  initial begin
    rx_byte_valid = 3'h0;
    rx_byte = 24'h0;
    frame_done = 3'h0;
    frame_proto = 6'h0;
    frame_ok = 3'h0;
  end
  // one byte, then the frame report; tags at the logic that keeps them
  task send(input int p, input logic [1:0] pr, input logic ok);
    @(posedge clk_sys);
    rx_byte_valid[p] <= 1'b1;
    rx_byte[8*p +: 8] <= {6'h0e, pr};
    @(posedge clk_sys);
    rx_byte_valid[p] <= 1'b0;
    rx_byte[8*p +: 8] <= ~{6'h0e, pr};
    frame_done[p] <= 1'b1;
    frame_proto[2*p +: 2] <= pr;
    frame_ok[p] <= ok;
    @(posedge clk_sys);
    frame_done[p] <= 1'b0;
    frame_proto[2*p +: 2] <= ~pr;
    frame_ok[p] <= ~ok;
  endtask
endmodule // spf_host_model

/* File: tb/spf_top_assertions.sv */
// Purpose: port-level checks for spf_top
// Assumes: one clk_sys domain, nrst active low
// Notes: frame link checks watch the lanes of ports one and two
module spf_checker #(
  parameter integer NPORT = 3
) (
  input wire clk_sys,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [NPORT-1:0] rx_byte_valid,
  input wire [NPORT*8-1:0] rx_byte,
  input wire [NPORT-1:0] buf_wr,
  input wire [NPORT*8-1:0] buf_data,
  input wire [NPORT-1:0] frame_done,
  input wire [NPORT*2-1:0] frame_proto,
  input wire [NPORT-1:0] frame_ok,
  input wire [NPORT-1:0] cmd_accept,
  input wire [NPORT-1:0] cmd_error_reply,
  input wire [NPORT*2-1:0] active_proto,
  input wire [NPORT-1:0] reply_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ****
  // bus and frame link
  // ****
  AST_ACCESS_ONE: assert property (
    psel && !penable |=> pready) else $error("access not one cycle");
  AST_READY_PULSE: assert property (
    pready |=> !pready) else $error("ready held too long");
  AST_ERR_IN_ACCESS: assert property (
    pslverr |-> pready && penable) else $error("stray slave error");
  AST_BUF_COPY: assert property (
    rx_byte_valid[0] |=> buf_wr[0] && buf_data[7:0] == $past(rx_byte[7:0]))
    else $error("byte not stored");
  AST_BUF_CAUSE: assert property (
    buf_wr[0] |-> $past(rx_byte_valid[0])) else $error("store without byte");
  AST_ACCEPT_CAUSE: assert property (
    cmd_accept[0] |-> $past(frame_done[0] && frame_ok[0])
      && active_proto[1:0] == $past(frame_proto[1:0]))
    else $error("accept without a good frame");
  AST_ERR_CAUSE: assert property (
    cmd_error_reply[0] |-> $past(frame_done[0] && !frame_ok[0]))
    else $error("error reply without a bad frame");
  AST_QUIET_NONE: assert property (
    !reply_enable[1] |-> !cmd_accept[1] && !cmd_error_reply[1])
    else $error("reply in no-protocol mode");
endmodule // spf_checker
bind spf_top spf_checker #(.NPORT(NPORT)) chk_u (.*);

/* File: tb/spf_top_tb_top.sv */
// Purpose: self-checking bench for spf_top
// Assumes: 20 MHz clk_sys, APB access, idle count shortened
// Notes: mask bit set lets the matching status bit reach irq
module spf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam integer IDLE = 50;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic soft_rst = 1'b0;
  logic halt_sw = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [2:0] rx_byte_valid, frame_done, frame_ok, buf_wr, cmd_accept;
  wire [2:0] cmd_error_reply, reply_enable, seven_bits, parity_en;
  wire [2:0] parity_odd, two_stop, baud_tick;
  wire [23:0] rx_byte, buf_data;
  wire [5:0] frame_proto, active_proto;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] codes [4] = '{8'hc4, 8'h5b, 8'hef, 8'h12};
  // free-running 50 ns clock
  always #25 clk_sys = ~clk_sys;
  spf_top #(.IDLE_CYC(IDLE)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
    .soft_rst(soft_rst), .halt_switch(halt_sw), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .frame_done(frame_done), .frame_proto(frame_proto),
    .frame_ok(frame_ok), .buf_wr(buf_wr), .buf_data(buf_data),
    .cmd_accept(cmd_accept), .cmd_error_reply(cmd_error_reply),
    .active_proto(active_proto), .reply_enable(reply_enable),
    .seven_bits(seven_bits), .parity_en(parity_en),
    .parity_odd(parity_odd), .two_stop(two_stop), .baud_tick(baud_tick),
    .irq(irq));
  spf_host_model host_u (.clk_sys(clk_sys), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .frame_done(frame_done),
    .frame_proto(frame_proto), .frame_ok(frame_ok));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles from one baud tick of port p to the next
  task automatic tick_gap(input int p, input int e);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (baud_tick[p] !== 1'b1 && n < 600);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (baud_tick[p] !== 1'b1 && n < 600);
    chk(n, e);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic end_sim;
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog, about five and a half times the 730 or so cycles the run needs
  initial begin
    #200000;
    bad_count++;
    end_sim;
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdchk(12'h000, 32'h06);
    chk({seven_bits[0], parity_en[0], parity_odd[0], two_stop[0]},
      0);
    foreach (codes[i]) begin
      apb(1'b1, 12'h008, {24'h0, codes[i]});
      rdchk(12'h008, {24'h0, codes[i]});
      chk({seven_bits[2], parity_en[2], parity_odd[2], two_stop[2]},
        codes[i][7:4]);
    end
    rdchk(12'h004, 32'h06);
    @(posedge clk_sys);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    rdchk(12'h008, 32'h12);
    tick_gap(0, 32);
    tick_gap(2, 260);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    rdchk(12'h018, 32'h0);
    host_u.send(0, 2'h2, 1'b1);
    #1 chk(cmd_accept[0], 1'b1);
    chk(active_proto[1:0], 2'h2);
    host_u.send(0, 2'h0, 1'b1);
    #1 chk(cmd_accept[0], 1'b0);
    host_u.send(0, 2'h2, 1'b0);
    #1 chk(cmd_error_reply[0], 1'b1);
    rdchk(12'h018, 32'h1);
    rdchk(12'h010, 32'h9);
    apb(1'b1, 12'h014, 32'h0);
    rdchk(12'h014, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, 12'h014, 32'h08);
    rdchk(12'h014, 32'h08);
    chk(irq, 1'b1);
    apb(1'b1, 12'h010, 32'h09);
    rdchk(12'h010, 32'h0);
    chk(irq, 1'b0);
    repeat (IDLE + 10) @(posedge clk_sys);
    rdchk(12'h018, 32'h0);
    apb(1'b1, 12'h00c, 32'h6088);
    rdchk(12'h018, 32'h38);
    chk(reply_enable[1], 1'b0);
    host_u.send(1, 2'h1, 1'b1);
    #1 chk(cmd_accept[1], 1'b0);
    host_u.send(2, 2'h1, 1'b1);
    #1 chk(cmd_accept[2], 1'b0);
    host_u.send(2, 2'h3, 1'b1);
    #1 chk(cmd_accept[2], 1'b1);
    repeat (IDLE + 10) @(posedge clk_sys);
    rdchk(12'h018, 32'h38);
    chk(active_proto[5:4], 2'h3);
    // power cycle with the halt switch on
    nrst <= 1'b0;
    halt_sw <= 1'b1;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdchk(12'h008, 32'h06);
    apb(1'b1, 12'h000, 32'hc4);
    rdchk(12'h000, 32'h06);
    apb(1'b1, 12'h00c, 32'h6088);
    rdchk(12'h018, 32'h0);
    apb(1'b1, 12'h004, 32'h5b);
    rdchk(12'h004, 32'h5b);
    end_sim;
  end
endmodule // spf_top_tb_top
